// [rtl/pcc_channel_regs.sv]
// Channel control registers of the seven-channel pulse width modulation controller
//
// Function
// - Disable write ones stop channels not enable-strobed that cycle, zeros ignored
// - State register shows enabled channels, bits 6-0
// - Enable-set write ones set mask bits
// - Enable-clear write ones clear mask bits
// - Mask view reads mask, resets zero
// - Period end sets channel status flag
// - Flags read clears them, coincident events kept
// - Prescale code picks counter clock source
// - Alignment bit: left or center aligned
// - Polarity bit: period starts low or high
// - Update target bit: duty or period
// - Interrupt high while flagged and unmasked
//
// The strobed register port was left to the implementer.
`default_nettype none
`include "pcc_defines.svh"

module pcc_channel_regs (
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  // Register port
  input  wire logic [`PCC_ADDR_W-1:0] addr_i,
  input  wire logic [31:0]            wr_data_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [31:0]            rd_data_o,
  // Channel side
  input  wire logic [`PCC_NCH-1:0]    chan_enable_set_i,
  input  wire logic [`PCC_NCH-1:0]    period_end_i,
  input  wire logic                   divider_a_tick_i,
  input  wire logic                   divider_b_tick_i,
  output logic      [`PCC_NCH-1:0]    chan_enable_o,
  output logic      [`PCC_NCH-1:0]    cnt_tick_o,
  output logic      [`PCC_NCH-1:0]    period_alignment_o,
  output logic      [`PCC_NCH-1:0]    output_polarity_o,
  output logic      [`PCC_NCH-1:0]    update_target_o,
  // Interrupt
  output logic                        irq_o
);

  pcc_pkg::pcc_state_type st_ff;
  pcc_pkg::pcc_state_type nxt_st;

  // True when the address selects the mode register of channel ch
  function automatic logic pcc_mode_hit(input logic [`PCC_ADDR_W-1:0] a,
                                        input int unsigned            ch);
    pcc_mode_hit = (a[9:8] == `PCC_MODE_HI) && (a[4:0] == `PCC_MODE_LO) &&
                   (32'(a[7:5]) == ch);
  endfunction : pcc_mode_hit

  // Counter clock strobe for one prescale code
  function automatic logic pcc_tick(input logic [3:0]            code,
                                    input logic [`PCC_CNT_W-1:0] cnt,
                                    input logic                  tick_a,
                                    input logic                  tick_b);
    logic [`PCC_CNT_W-1:0] low;
    low = ~(10'h3FF << code);
    if (code <= `PCC_PRE_DIV_MAX) begin
      pcc_tick = &(cnt | ~low);
    end else if (code == `PCC_PRE_CLK_A) begin
      pcc_tick = tick_a;
    end else if (code == `PCC_PRE_CLK_B) begin
      pcc_tick = tick_b;
    end else begin
      // Reserved codes leave the counter stopped
      pcc_tick = 1'b0;
    end
  endfunction : pcc_tick

  logic wr_disable;
  logic wr_irq_set;
  logic wr_irq_clr;
  logic rd_flags;

  assign wr_disable = wr_i && (addr_i == `PCC_OFF_DISABLE);
  assign wr_irq_set = wr_i && (addr_i == `PCC_OFF_IRQ_SET);
  assign wr_irq_clr = wr_i && (addr_i == `PCC_OFF_IRQ_CLR);
  assign rd_flags   = rd_i && (addr_i == `PCC_OFF_FLAGS);

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.rdata   = `PCC_RST_WORD;
    nxt_st.pre_cnt = st_ff.pre_cnt + 10'h001;

    // One vector operation per access moves every selected channel at once
    if (wr_disable) begin
      nxt_st.chan_en = st_ff.chan_en & ~wr_data_i[`PCC_NCH-1:0];
    end
    // Enable strobe from the channel side wins over a coincident disable
    nxt_st.chan_en = nxt_st.chan_en | chan_enable_set_i;

    if (wr_irq_set) begin
      nxt_st.mask = st_ff.mask | wr_data_i[`PCC_NCH-1:0];
    end
    if (wr_irq_clr) begin
      nxt_st.mask = st_ff.mask & ~wr_data_i[`PCC_NCH-1:0];
    end

    // Clear first, then set, so an event landing on the read survives
    if (rd_flags) begin
      nxt_st.flags = `PCC_RST_FLAGS;
    end
    nxt_st.flags = nxt_st.flags | period_end_i;

    for (int i = 0; i < `PCC_NCH; i++) begin
      if (wr_i && pcc_mode_hit(addr_i, i)) begin
        nxt_st.mode[i].channel_prescale = wr_data_i[`PCC_PRE_HI:`PCC_PRE_LO];
        nxt_st.mode[i].update_target    = wr_data_i[`PCC_BIT_UPD];
        // Shape bits only move while the channel is stopped
        if (!st_ff.chan_en[i]) begin
          nxt_st.mode[i].period_alignment = wr_data_i[`PCC_BIT_ALIGN];
          nxt_st.mode[i].output_polarity  = wr_data_i[`PCC_BIT_POL];
        end
      end
    end

    // Write-only and unmapped addresses read back zero
    if (rd_i) begin
      case (addr_i)
        `PCC_OFF_STATE: begin
          nxt_st.rdata = {25'h000_0000, st_ff.chan_en};
        end
        `PCC_OFF_IRQ_MASK: begin
          nxt_st.rdata = {25'h000_0000, st_ff.mask};
        end
        `PCC_OFF_FLAGS: begin
          nxt_st.rdata = {25'h000_0000, st_ff.flags};
        end
        default: begin
          for (int i = 0; i < `PCC_NCH; i++) begin
            if (pcc_mode_hit(addr_i, i)) begin
              nxt_st.rdata = {21'h00_0000,
                              st_ff.mode[i].update_target,
                              st_ff.mode[i].output_polarity,
                              st_ff.mode[i].period_alignment,
                              4'h0,
                              st_ff.mode[i].channel_prescale};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff.chan_en <= `PCC_RST_CHAN;
      st_ff.mask    <= `PCC_RST_MASK;
      st_ff.flags   <= `PCC_RST_FLAGS;
      st_ff.mode    <= '0;
      st_ff.pre_cnt <= '0;
      st_ff.rdata   <= `PCC_RST_WORD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data_o     = st_ff.rdata;
  assign chan_enable_o = st_ff.chan_en;
  assign irq_o         = |(st_ff.flags & st_ff.mask);

  generate
    for (genvar g = 0; g < `PCC_NCH; g++) begin : g_chan
      assign period_alignment_o[g] = st_ff.mode[g].period_alignment;
      assign output_polarity_o[g]  = st_ff.mode[g].output_polarity;
      assign update_target_o[g]    = st_ff.mode[g].update_target;
      assign cnt_tick_o[g]         = pcc_tick(st_ff.mode[g].channel_prescale,
                                              st_ff.pre_cnt,
                                              divider_a_tick_i,
                                              divider_b_tick_i);
    end
  endgenerate

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  dis_stops_chan_a: assert property (
    wr_disable && (chan_enable_set_i == 7'h00)
    |=> (chan_enable_o & $past(wr_data_i[6:0])) == 7'h00)
    else $error("disabled channel still enabled");

  dis_keeps_rest_a: assert property (
    wr_disable
    |=> ((chan_enable_o ^ $past(chan_enable_o)) & ~$past(wr_data_i[6:0])
         & ~$past(chan_enable_set_i)) == 7'h00)
    else $error("unselected channel changed on disable");

  state_read_a: assert property (
    rd_i && (addr_i == `PCC_OFF_STATE)
    |=> rd_data_o == {25'h000_0000, $past(chan_enable_o)})
    else $error("state read mismatch");

  irq_set_mask_a: assert property (
    wr_irq_set
    |=> (st_ff.mask & $past(wr_data_i[6:0])) == $past(wr_data_i[6:0])
        && (st_ff.mask & ~$past(wr_data_i[6:0])) == ($past(st_ff.mask)
        & ~$past(wr_data_i[6:0])))
    else $error("enable-set did not update mask");

  irq_clr_mask_a: assert property (
    wr_irq_clr
    |=> st_ff.mask == ($past(st_ff.mask) & ~$past(wr_data_i[6:0])))
    else $error("enable-clear did not update mask");

  mask_read_a: assert property (
    rd_i && (addr_i == `PCC_OFF_IRQ_MASK)
    |=> rd_data_o == {25'h000_0000, $past(st_ff.mask)})
    else $error("mask read mismatch");

  flag_set_a: assert property (
    (period_end_i != 7'h00)
    |=> (st_ff.flags & $past(period_end_i)) == $past(period_end_i))
    else $error("period end lost");

  flag_read_clr_a: assert property (
    rd_flags
    |=> st_ff.flags == $past(period_end_i)
        && rd_data_o == {25'h000_0000, $past(st_ff.flags)})
    else $error("flags read did not clear or lost event");

  irq_level_a: assert property (
    irq_o == ((st_ff.flags & st_ff.mask) != 7'h00))
    else $error("interrupt level wrong");

  irq_hold_a: assert property (
    irq_o && !rd_flags && !wr_irq_clr |=> irq_o)
    else $error("interrupt dropped without flags read");

  tick_full_rate_a: assert property (
    st_ff.mode[0].channel_prescale == 4'h0 |-> cnt_tick_o[0])
    else $error("undivided clock missing tick");

  // A code change on the next edge may legally restart the pattern
  tick_div2_a: assert property (
    st_ff.mode[0].channel_prescale == 4'h1 && cnt_tick_o[0]
    |=> !cnt_tick_o[0] || st_ff.mode[0].channel_prescale != 4'h1)
    else $error("half-rate tick back to back");

  shape_lock_a: assert property (
    wr_i && pcc_mode_hit(addr_i, 0) && chan_enable_o[0]
    |=> $stable(output_polarity_o[0]) && $stable(period_alignment_o[0]))
    else $error("shape bits changed while enabled");

  upd_target_a: assert property (
    wr_i && pcc_mode_hit(addr_i, 0)
    |=> update_target_o[0] == $past(wr_data_i[10]))
    else $error("update target not stored");

  ro_write_a: assert property (
    wr_i && (addr_i == `PCC_OFF_IRQ_MASK) |=> $stable(st_ff.mask))
    else $error("mask view write took effect");

  wo_read_a: assert property (
    rd_i && (addr_i == `PCC_OFF_DISABLE) |=> rd_data_o == 32'h0000_0000)
    else $error("write-only register read nonzero");

  wo_irq_read_a: assert property (
    rd_i && (addr_i == `PCC_OFF_IRQ_SET || addr_i == `PCC_OFF_IRQ_CLR)
    |=> rd_data_o == 32'h0000_0000)
    else $error("enable register read nonzero");

  // Read port idles at zero so a stray sample never sees old data
  rdata_idle_a: assert property (
    !rd_i |=> rd_data_o == 32'h0000_0000)
    else $error("read data outside read cycle");

  // Enables move only on their own strobes
  chan_fall_a: assert property (
    !wr_disable |=> (~chan_enable_o & $past(chan_enable_o)) == 7'h00)
    else $error("channel stopped without disable");

  chan_rise_a: assert property (
    chan_enable_set_i == 7'h00 |=> (chan_enable_o & ~$past(chan_enable_o)) == 7'h00)
    else $error("channel started without enable");

  enable_set_a: assert property (
    chan_enable_set_i != 7'h00
    |=> (chan_enable_o & $past(chan_enable_set_i)) == $past(chan_enable_set_i))
    else $error("selected channels not all enabled");

  mask_hold_a: assert property (
    !wr_irq_set && !wr_irq_clr |=> $stable(st_ff.mask))
    else $error("mask moved without write");

  // Flags rise only on period ends and fall only on the read
  flag_keep_a: assert property (
    !rd_flags |=> (st_ff.flags & $past(st_ff.flags)) == $past(st_ff.flags))
    else $error("flag lost without read");

  flag_cause_a: assert property (
    period_end_i == 7'h00 && !rd_flags |=> $stable(st_ff.flags))
    else $error("flag moved without cause");

  irq_read_clr_a: assert property (
    rd_flags && period_end_i == 7'h00 |=> !irq_o)
    else $error("interrupt kept after flags read");

  // Channel 0 stands in for all; every channel goes through the same write and read decode loops and one tick generate loop
  mode_hold_a: assert property (
    !(wr_i && pcc_mode_hit(addr_i, 0)) |=> $stable(st_ff.mode[0]))
    else $error("mode changed without write");

  pre_store_a: assert property (
    wr_i && pcc_mode_hit(addr_i, 0)
    |=> st_ff.mode[0].channel_prescale == $past(wr_data_i[3:0]))
    else $error("prescale code not stored");

  shape_store_a: assert property (
    wr_i && pcc_mode_hit(addr_i, 0) && !chan_enable_o[0]
    |=> period_alignment_o[0] == $past(wr_data_i[8])
        && output_polarity_o[0] == $past(wr_data_i[9]))
    else $error("shape bits not stored while stopped");

  mode_read_a: assert property (
    rd_i && pcc_mode_hit(addr_i, 0)
    |=> rd_data_o == {21'h00_0000,
                      $past(update_target_o[0]),
                      $past(output_polarity_o[0]),
                      $past(period_alignment_o[0]),
                      4'h0,
                      $past(st_ff.mode[0].channel_prescale)})
    else $error("mode read mismatch");

  tick_first_div_a: assert property (
    st_ff.mode[0].channel_prescale == `PCC_PRE_CLK_A |-> cnt_tick_o[0] == divider_a_tick_i)
    else $error("divider A tick not passed");

  tick_second_div_a: assert property (
    st_ff.mode[0].channel_prescale == `PCC_PRE_CLK_B |-> cnt_tick_o[0] == divider_b_tick_i)
    else $error("divider B tick not passed");

  // Reserved codes stop the counter rather than guess a rate
  tick_reserved_a: assert property (
    st_ff.mode[0].channel_prescale > `PCC_PRE_CLK_B |-> !cnt_tick_o[0])
    else $error("reserved code produced a tick");

  tick_slowest_a: assert property (
    st_ff.mode[0].channel_prescale == `PCC_PRE_DIV_MAX
    |-> cnt_tick_o[0] == (&st_ff.pre_cnt))
    else $error("slowest tick off its count");

  tick_slow_gap_a: assert property (
    st_ff.mode[0].channel_prescale == `PCC_PRE_DIV_MAX && cnt_tick_o[0]
    |=> !cnt_tick_o[0] || st_ff.mode[0].channel_prescale != `PCC_PRE_DIV_MAX)
    else $error("slowest tick back to back");

endmodule : pcc_channel_regs

`default_nettype wire

// [rtl/pcc_defines.svh]
// Offsets, field positions, reset values and counts of the channel control registers
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

`define PCC_NCH            7
`define PCC_ADDR_W         10
`define PCC_CNT_W          10

`define PCC_OFF_DISABLE    10'h008
`define PCC_OFF_STATE      10'h00C
`define PCC_OFF_IRQ_SET    10'h010
`define PCC_OFF_IRQ_CLR    10'h014
`define PCC_OFF_IRQ_MASK   10'h018
`define PCC_OFF_FLAGS      10'h01C
`define PCC_OFF_MODE_BASE  10'h200

`define PCC_MODE_HI        2'h2
`define PCC_MODE_LO        5'h00

`define PCC_BIT_ALIGN      8
`define PCC_BIT_POL        9
`define PCC_BIT_UPD        10
`define PCC_PRE_HI         3
`define PCC_PRE_LO         0

`define PCC_PRE_DIV_MAX    4'hA
`define PCC_PRE_CLK_A      4'hB
`define PCC_PRE_CLK_B      4'hC

`define PCC_RST_CHAN       7'h00
`define PCC_RST_MASK       7'h00
`define PCC_RST_FLAGS      7'h00
`define PCC_RST_MODE       7'h00
`define PCC_RST_WORD       32'h0000_0000

`endif

// [rtl/pcc_pkg.sv]
// Types of the channel control registers
`default_nettype none
`include "pcc_defines.svh"

package pcc_pkg;

  typedef struct packed {
    logic       update_target;
    logic       output_polarity;
    logic       period_alignment;
    logic [3:0] channel_prescale;
  } pcc_mode_type;

  typedef struct packed {
    logic [`PCC_NCH-1:0]   chan_en;
    logic [`PCC_NCH-1:0]   mask;
    logic [`PCC_NCH-1:0]   flags;
    pcc_mode_type [`PCC_NCH-1:0] mode;
    logic [`PCC_CNT_W-1:0] pre_cnt;
    logic [31:0]           rdata;
  } pcc_state_type;

endpackage : pcc_pkg

`default_nettype wire

// [tb/pcc_channel_regs_tb_top.sv]
// Self-checking bench for the channel control registers
`default_nettype none
`include "pcc_defines.svh"

module pcc_channel_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic       wr;
    logic [9:0] addr;
    logic [31:0] data;
  } pcc_row_type;

  logic                   clk_sys_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic [`PCC_ADDR_W-1:0] addr_i = '0;
  logic [31:0]            wr_data_i = '0;
  logic                   wr_i = 1'b0;
  logic                   rd_i = 1'b0;
  logic [31:0]            rd_data_o;
  logic [`PCC_NCH-1:0]    chan_enable_set_i = '0;
  logic [`PCC_NCH-1:0]    period_end_i = '0;
  logic                   divider_a_tick_i = 1'b0;
  logic                   divider_b_tick_i = 1'b0;
  logic [`PCC_NCH-1:0]    chan_enable_o;
  logic [`PCC_NCH-1:0]    cnt_tick_o;
  logic [`PCC_NCH-1:0]    period_alignment_o;
  logic [`PCC_NCH-1:0]    output_polarity_o;
  logic [`PCC_NCH-1:0]    update_target_o;
  logic                   irq_o;
  int                     mismatches = 0;
  int                     compares = 0;
  int                     cyc = 0;
  int                     n;
  int                     na;
  int                     nb;
  int                     e;

  // Write rows mixed with read rows carrying the expected word
  localparam pcc_row_type rows [15] = '{
    '{1'b1, `PCC_OFF_IRQ_SET, 32'h0000_0005}, '{1'b0, `PCC_OFF_IRQ_MASK, 32'h0000_0005},
    '{1'b1, `PCC_OFF_IRQ_CLR, 32'h0000_0004}, '{1'b0, `PCC_OFF_IRQ_MASK, 32'h0000_0001},
    '{1'b1, `PCC_OFF_IRQ_MASK, 32'h0000_007F}, '{1'b0, `PCC_OFF_IRQ_MASK, 32'h0000_0001},
    '{1'b0, `PCC_OFF_DISABLE, 32'h0000_0000}, '{1'b0, `PCC_OFF_IRQ_SET, 32'h0000_0000},
    '{1'b1, 10'h200, 32'h0000_070B}, '{1'b0, 10'h200, 32'h0000_070B},
    '{1'b1, 10'h2C0, 32'hFFFF_FFFF}, '{1'b0, 10'h2C0, 32'h0000_070F},
    '{1'b0, 10'h004, 32'h0000_0000}, '{1'b1, `PCC_OFF_STATE, 32'h0000_007F},
    '{1'b0, `PCC_OFF_STATE, 32'h0000_0000}};

  pcc_channel_regs pcc_channel_regs_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .chan_enable_set_i(chan_enable_set_i),
    .period_end_i(period_end_i), .divider_a_tick_i(divider_a_tick_i),
    .divider_b_tick_i(divider_b_tick_i), .chan_enable_o(chan_enable_o),
    .cnt_tick_o(cnt_tick_o), .period_alignment_o(period_alignment_o),
    .output_polarity_o(output_polarity_o), .update_target_o(update_target_o), .irq_o(irq_o));

  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // Divider ticks on unrelated spacings so the two sources are told apart
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    divider_a_tick_i <= (cyc % 3 == 0);
    divider_b_tick_i <= (cyc % 5 == 0);
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_pins(input logic [6:0] got, input logic [6:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_pins

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the read edge
  task automatic rd(input logic [9:0] a, input logic [31:0] exp, input logic [6:0] ev);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    period_end_i <= ev;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    period_end_i <= '0;
    #1 chk_word(rd_data_o, exp);
  endtask : rd

  task automatic wrap_up;
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (40000) @(posedge clk_sys_i);
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(`PCC_OFF_FLAGS, 32'h0000_0000, 7'h00);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].data);
      end else begin
        rd(rows[i].addr, rows[i].data, 7'h00);
      end
    end
    chk_pins(period_alignment_o, 7'h41);
    chk_pins(output_polarity_o, 7'h41);
    chk_pins(update_target_o, 7'h41);
    @(posedge clk_sys_i);
    chan_enable_set_i <= 7'h7F;
    @(posedge clk_sys_i);
    chan_enable_set_i <= 7'h00;
    rd(`PCC_OFF_STATE, 32'h0000_007F, 7'h00);
    wr(`PCC_OFF_DISABLE, 32'h0000_000A);
    #1 chk_pins(chan_enable_o, 7'h75);
    rd(`PCC_OFF_STATE, 32'h0000_0075, 7'h00);
    @(posedge clk_sys_i);
    period_end_i <= 7'h03;
    @(posedge clk_sys_i);
    period_end_i <= 7'h00;
    #1 chk_pins({6'h00, irq_o}, 7'h01);
    // Channel 1 ends a period on the very edge of the clearing read
    rd(`PCC_OFF_FLAGS, 32'h0000_0003, 7'h02);
    chk_pins({6'h00, irq_o}, 7'h00);
    rd(`PCC_OFF_FLAGS, 32'h0000_0002, 7'h00);
    rd(`PCC_OFF_FLAGS, 32'h0000_0000, 7'h00);
    for (int code = 0; code < 16; code++) begin
      wr(10'h200, 32'(code));
      n = 0;
      na = 0;
      nb = 0;
      repeat (1024) begin
        @(negedge clk_sys_i);
        n += int'(cnt_tick_o[0]);
        na += int'(divider_a_tick_i);
        nb += int'(divider_b_tick_i);
      end
      e = (code <= 10) ? (1024 >> code) : (code == 11) ? na : (code == 12) ? nb : 0;
      chk_word(32'(n), 32'(e));
    end
    // Second reset in mid-run with an interrupt pending
    wr(`PCC_OFF_IRQ_SET, 32'h0000_007F);
    @(posedge clk_sys_i);
    period_end_i <= 7'h7F;
    @(posedge clk_sys_i);
    period_end_i <= 7'h00;
    #1 chk_pins({6'h00, irq_o}, 7'h01);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    #1 chk_pins({6'h00, irq_o}, 7'h00);
    chk_pins(chan_enable_o, 7'h00);
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(`PCC_OFF_IRQ_MASK, 32'h0000_0000, 7'h00);
    rd(10'h200, 32'h0000_0000, 7'h00);
    chk_pins(cnt_tick_o, 7'h7F);
    wrap_up();
  end
endmodule : pcc_channel_regs_tb_top

`default_nettype wire
